// ==== logic/rtc_pkg.sv ====
// Shared constants for the clock/alarm/time block.
// Assumes a 32-bit AXI4-Lite slave and a single system clock.
package rtc_pkg;
	// Register byte offsets (8-bit address space)
	localparam logic [7:0]  OFS_CONTROL = 8'h00;
	localparam logic [7:0]  OFS_ALARM   = 8'h10;
	localparam logic [7:0]  OFS_TIME    = 8'h20;
	localparam logic [7:0]  OFS_UNLOCK  = 8'h30;
	// Control register fields
	localparam int          ON_BIT      = 15;
	localparam int          SIDL_BIT    = 13;
	localparam int          SEL_BIT     = 7;
	localparam int          VWE_BIT     = 3;
	localparam int          OE_BIT      = 0;
	localparam int          CAL_LSB     = 16;
	// Alarm control fields
	localparam int          AEN_BIT     = 15;
	localparam int          WRAP_BIT    = 14;
	localparam int          PIV_BIT     = 13;
	localparam int          ALARM_INTERVAL_SELECT_LSB   = 8;
	localparam int          RPT_LSB     = 0;
	// BCD digit positions in time and date words
	localparam int          SEC_U       = 8;
	localparam int          SEC_T       = 12;
	localparam int          MIN_U       = 16;
	localparam int          MIN_T       = 20;
	localparam int          HR_U        = 24;
	localparam int          HR_T        = 28;
	localparam int          WDAY_LSB    = 0;
	localparam int          DAY_LSB     = 8;
	localparam int          MON_LSB     = 16;
	localparam int          YEAR_LSB    = 24;
	localparam logic [31:0] TIME_MASK   = 32'h3F7F_7F00;
	localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
	// Unlock keys, arbitrary values
	localparam logic [31:0] KEY_A       = 32'h0000_5A5A;
	localparam logic [31:0] KEY_B       = 32'h0000_A5A5;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	// Timing
	localparam int          SYS_CLK_HZ  = 250_000_000;
	localparam int          RTC_CLK_HZ  = 32768;
	localparam int          RTC_DIV     = SYS_CLK_HZ / RTC_CLK_HZ;
	localparam int          HALF_TICKS  = RTC_CLK_HZ / 2;
	localparam int          SYNC_TICKS  = 32;
	typedef enum logic [3:0] {
		IV_HALF, IV_SEC, IV_10SEC, IV_MIN, IV_10MIN,
		IV_HOUR, IV_DAY, IV_WEEK, IV_MONTH, IV_YEAR
	} interval_t;
endpackage

// ==== logic/reg_if.sv ====
// Register access strobes between the bus slave and the core.
// Assumes both ends share one clock; strobes are one cycle.
`timescale 1ns/1ps
interface reg_if;
	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        wr_ok;
	logic        rd_en;
	logic [7:0]  rd_addr;
	logic [31:0] rd_data;
	logic        rd_ok;
	modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		input wr_ok, rd_data, rd_ok);
	modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		output wr_ok, rd_data, rd_ok);
endinterface

// ==== logic/axil_slave.sv ====
// AXI4-Lite slave that turns bus transfers into register strobes.
// Assumes the register side answers rd_data and ok flags combinationally.
`timescale 1ns/1ps
module axil_slave (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic [7:0] awaddr_in,
	input  wire logic       awvalid_in,
	output logic            awready_out,
	input  wire logic [31:0] wdata_in,
	input  wire logic [3:0] wstrb_in,
	input  wire logic       wvalid_in,
	output logic            wready_out,
	output logic [1:0]      bresp_out,
	output logic            bvalid_out,
	input  wire logic       bready_in,
	input  wire logic [7:0] araddr_in,
	input  wire logic       arvalid_in,
	output logic            arready_out,
	output logic [31:0]     rdata_out,
	output logic [1:0]      rresp_out,
	output logic            rvalid_out,
	input  wire logic       rready_in,
	reg_if.bus              rif
);
	import rtc_pkg::*;
	typedef struct packed {
		logic        aw_full;
		logic        w_full;
		logic        ar_full;
		logic [7:0]  waddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic [7:0]  raddr;
		logic        awready;
		logic        wready;
		logic        arready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} slave_t;
	slave_t s;
	slave_t n;
	logic   do_wr;
	logic   do_rd;
	// A write commits only once the previous response has been taken
	assign do_wr = s.aw_full && s.w_full && !s.bvalid;
	assign do_rd = s.ar_full && !s.rvalid;
	always_comb
	begin
		n = s;
		if (awvalid_in && s.awready)
		begin
			n.aw_full = 1'b1;
			n.waddr = awaddr_in;
		end
		if (wvalid_in && s.wready)
		begin
			n.w_full = 1'b1;
			n.wdata = wdata_in;
			n.wstrb = wstrb_in;
		end
		if (s.bvalid && bready_in)
			n.bvalid = 1'b0;
		if (do_wr)
		begin
			n.aw_full = 1'b0;
			n.w_full = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = rif.wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		if (arvalid_in && s.arready)
		begin
			n.ar_full = 1'b1;
			n.raddr = araddr_in;
		end
		if (s.rvalid && rready_in)
			n.rvalid = 1'b0;
		if (do_rd)
		begin
			n.ar_full = 1'b0;
			n.rvalid = 1'b1;
			n.rdata = rif.rd_ok ? rif.rd_data : RESET_WORD;
			n.rresp = rif.rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		n.awready = !n.aw_full;
		n.wready = !n.w_full;
		n.arready = !n.ar_full && !n.rvalid;
	end
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			s <= '0;
		else
			s <= n;
	end
	assign rif.wr_en = do_wr;
	assign rif.wr_addr = s.waddr;
	assign rif.wr_data = s.wdata;
	assign rif.wr_strb = s.wstrb;
	assign rif.rd_en = do_rd;
	assign rif.rd_addr = s.raddr;
	assign awready_out = s.awready;
	assign wready_out = s.wready;
	assign bvalid_out = s.bvalid;
	assign bresp_out = s.bresp;
	assign arready_out = s.arready;
	assign rvalid_out = s.rvalid;
	assign rdata_out = s.rdata;
	assign rresp_out = s.rresp;
endmodule

// ==== logic/rtc_core.sv ====
// Clock control, alarm control and BCD time keeping, AXI4-Lite slave.
// Assumes date, alarm time and alarm date come from logic on sys_clk_in.
`timescale 1ns/1ps
module rtc_core #(
	parameter int RTC_DIV_CYCLES = rtc_pkg::RTC_DIV,
	parameter int HALF_SEC_TICKS = rtc_pkg::HALF_TICKS
) (
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	input  wire logic [7:0]  axi_awaddr_in,
	input  wire logic        axi_awvalid_in,
	output logic             axi_awready_out,
	input  wire logic [31:0] axi_wdata_in,
	input  wire logic [3:0]  axi_wstrb_in,
	input  wire logic        axi_wvalid_in,
	output logic             axi_wready_out,
	output logic [1:0]       axi_bresp_out,
	output logic             axi_bvalid_out,
	input  wire logic        axi_bready_in,
	input  wire logic [7:0]  axi_araddr_in,
	input  wire logic        axi_arvalid_in,
	output logic             axi_arready_out,
	output logic [31:0]      axi_rdata_out,
	output logic [1:0]       axi_rresp_out,
	output logic             axi_rvalid_out,
	input  wire logic        axi_rready_in,
	input  wire logic [31:0] date_value_in,
	input  wire logic [31:0] alarm_time_in,
	input  wire logic [31:0] alarm_date_in,
	output logic             rtc_pin_out,
	output logic             rtc_pin_oe_out,
	output logic             day_rollover_out,
	output logic             alarm_event_out
);
	import rtc_pkg::*;

	localparam logic [15:0] DIV_TOP = 16'(RTC_DIV_CYCLES - 1);
	localparam logic signed [16:0] PTOP = 17'(HALF_SEC_TICKS - 1);
	localparam logic signed [16:0] PNEAR =
		17'(HALF_SEC_TICKS - 1 - SYNC_TICKS);

	typedef struct packed {
		logic        on;
		logic        sidl;
		logic        sel;
		logic        vwe;
		logic        oe;
		logic [9:0]  cal;
		logic        aen;
		logic        wrap;
		logic        pulse;
		logic [3:0]  alarm_interval_select;
		logic [7:0]  rpt;
		logic [31:0] tv;
		logic        half;
		logic [15:0] div;
		logic [16:0] presc;
		logic        key1;
		logic        armed;
		logic        check;
		logic        pin;
		logic        pin_oe;
		logic        day;
		logic        evt;
	} core_t;

	core_t              s;
	core_t              n;
	reg_if              rif ();
	logic signed [16:0] presc_s;
	logic               near;
	logic               ripple;
	logic [31:0]        ctrl_rd;
	logic [31:0]        alarm_rd;
	logic [31:0]        time_rd;
	logic [31:0]        old_word;
	logic [31:0]        w;
	logic [7:0]         wa;
	logic               tick;
	logic               half_tick;
	logic               sec_tick;
	logic [33:0]        inc;
	logic               evt;

	// Word-aligned decode; the low two address bits are ignored
	function automatic logic [7:0] align(input logic [7:0] a);
		return {a[7:2], 2'h0};
	endfunction

	function automatic logic hit(input logic [7:0] a);
		logic [7:0] b;
		b = align(a);
		return b == OFS_CONTROL || b == OFS_ALARM || b == OFS_TIME ||
			b == OFS_UNLOCK;
	endfunction

	function automatic logic [31:0] pick(input logic [7:0] a,
		input logic [31:0] c, input logic [31:0] al,
		input logic [31:0] t);
		logic [7:0] b;
		b = align(a);
		if (b == OFS_CONTROL)
			return c;
		if (b == OFS_ALARM)
			return al;
		if (b == OFS_TIME)
			return t;
		return RESET_WORD;
	endfunction

	// Byte lanes without a strobe keep their old contents
	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] d, input logic [3:0] st);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
			if (st[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		return r;
	endfunction

	// One BCD digit step; back to zero, with no carry bit set, when the digit was at its top
	function automatic logic [4:0] digit_inc(input logic [3:0] d,
		input logic [3:0] top);
		if (d >= top)
			return 5'h00;
		return {1'b0, d + 4'h1};
	endfunction

	// Returns {hour-units carry, minute carry, next time word}
	function automatic logic [33:0] time_inc(input logic [31:0] t);
		logic [31:0] r;
		logic [4:0]  d;
		logic        c;
		logic        m;
		logic [3:0]  hu_top;
		r = t;
		m = 1'b0;
		d = digit_inc(t[SEC_U +: 4], 4'h9);
		r[SEC_U +: 4] = d[3:0];
		c = (t[SEC_U +: 4] >= 4'h9);
		if (c)
		begin
			d = digit_inc({1'b0, t[SEC_T +: 3]}, 4'h5);
			r[SEC_T +: 3] = d[2:0];
			c = ({1'b0, t[SEC_T +: 3]} >= 4'h5);
			m = c;
		end
		if (c)
		begin
			d = digit_inc(t[MIN_U +: 4], 4'h9);
			r[MIN_U +: 4] = d[3:0];
			c = (t[MIN_U +: 4] >= 4'h9);
		end
		if (c)
		begin
			d = digit_inc({1'b0, t[MIN_T +: 3]}, 4'h5);
			r[MIN_T +: 3] = d[2:0];
			c = ({1'b0, t[MIN_T +: 3]} >= 4'h5);
		end
		hu_top = (t[HR_T +: 2] >= 2'h2) ? 4'h3 : 4'h9;
		if (c)
		begin
			d = digit_inc(t[HR_U +: 4], hu_top);
			r[HR_U +: 4] = d[3:0];
			c = (t[HR_U +: 4] >= hu_top);
		end
		if (c)
			r[HR_T +: 2] = (t[HR_T +: 2] >= 2'h2) ? 2'h0 :
				t[HR_T +: 2] + 2'h1;
		return {c, m, r};
	endfunction

	// h is the half-second status just after the rollover
	function automatic logic alarm_match(input logic [3:0] m,
		input logic h, input logic [31:0] t, input logic [31:0] d,
		input logic [31:0] at, input logic [31:0] ad);
		logic su;
		logic sec;
		logic mu;
		logic mi;
		logic hr;
		logic dy;
		logic mo;
		logic leap;
		logic feb29;
		su = t[SEC_U +: 4] == at[SEC_U +: 4];
		sec = su && t[SEC_T +: 3] == at[SEC_T +: 3];
		mu = sec && t[MIN_U +: 4] == at[MIN_U +: 4];
		mi = mu && t[MIN_T +: 3] == at[MIN_T +: 3];
		hr = mi && t[HR_U +: 6] == at[HR_U +: 6];
		dy = d[DAY_LSB +: 6] == ad[DAY_LSB +: 6];
		mo = d[MON_LSB +: 5] == ad[MON_LSB +: 5];
		// Year divisible by four, from its two BCD digits
		if (d[YEAR_LSB + 4])
			leap = d[YEAR_LSB +: 4] == 4'h2 || d[YEAR_LSB +: 4] == 4'h6;
		else
			leap = d[YEAR_LSB +: 4] == 4'h0 ||
				d[YEAR_LSB +: 4] == 4'h4 || d[YEAR_LSB +: 4] == 4'h8;
		feb29 = ad[MON_LSB +: 5] == 5'h02 && ad[DAY_LSB +: 6] == 6'h29;
		unique case (interval_t'(m))
			IV_HALF:  return 1'b1;
			IV_SEC:   return !h;
			IV_10SEC: return !h && su;
			IV_MIN:   return !h && sec;
			IV_10MIN: return !h && mu;
			IV_HOUR:  return !h && mi;
			IV_DAY:   return !h && hr;
			IV_WEEK:  return !h && hr &&
				d[WDAY_LSB +: 3] == ad[WDAY_LSB +: 3];
			IV_MONTH: return !h && hr && dy;
			IV_YEAR:  return !h && hr && dy && mo && (!feb29 || leap);
			default:  return 1'b0;
		endcase
	endfunction

	axil_slave u_bus (
		.clk_in      (sys_clk_in),
		.rst_in      (rst_in),
		.awaddr_in   (axi_awaddr_in),
		.awvalid_in  (axi_awvalid_in),
		.awready_out (axi_awready_out),
		.wdata_in    (axi_wdata_in),
		.wstrb_in    (axi_wstrb_in),
		.wvalid_in   (axi_wvalid_in),
		.wready_out  (axi_wready_out),
		.bresp_out   (axi_bresp_out),
		.bvalid_out  (axi_bvalid_out),
		.bready_in   (axi_bready_in),
		.araddr_in   (axi_araddr_in),
		.arvalid_in  (axi_arvalid_in),
		.arready_out (axi_arready_out),
		.rdata_out   (axi_rdata_out),
		.rresp_out   (axi_rresp_out),
		.rvalid_out  (axi_rvalid_out),
		.rready_in   (axi_rready_in),
		.rif         (rif.bus)
	);

	assign presc_s = $signed(s.presc);
	assign near = s.on && (presc_s > PNEAR);
	// ripple only near a full-second rollover
	assign ripple = near && s.half;
	assign ctrl_rd = {6'h00, s.cal, s.on, 1'b0, s.sidl, 5'h00, s.sel,
		s.on, 2'h0, s.vwe, ripple, s.half, s.oe};
	assign alarm_rd = {16'h0000, s.aen, s.wrap, s.pulse, near, s.alarm_interval_select,
		s.rpt};
	assign time_rd = s.tv & TIME_MASK;

	assign rif.rd_ok = hit(rif.rd_addr);
	assign rif.wr_ok = hit(rif.wr_addr);
	assign rif.rd_data = pick(rif.rd_addr, ctrl_rd, alarm_rd, time_rd);
	assign old_word = pick(rif.wr_addr, ctrl_rd, alarm_rd, time_rd);
	assign w = merge(old_word, rif.wr_data, rif.wr_strb);
	assign wa = align(rif.wr_addr);

	assign tick = s.div == DIV_TOP;
	// time base runs only while enabled
	assign half_tick = s.on && tick && (presc_s >= PTOP);
	assign sec_tick = half_tick && s.half;
	assign inc = time_inc(s.tv);
	assign evt = s.check && s.aen && alarm_match(s.alarm_interval_select, s.half, s.tv,
		date_value_in, alarm_time_in, alarm_date_in);

	always_comb
	begin
		n = s;
		n.check = 1'b0;
		n.day = 1'b0;
		n.evt = 1'b0;
		if (!s.on)
			n.div = 16'h0000;
		else
			n.div = tick ? 16'h0000 : s.div + 16'h0001;
		if (half_tick)
		begin
			n.half = ~s.half;
			n.presc = 17'h0_0000;
			n.check = 1'b1;
		end
		else if (s.on && tick)
			n.presc = s.presc + 17'h0_0001;
		if (sec_tick)
		begin
			n.tv = inc[31:0];
			n.day = inc[33];
			if (inc[32])
				n.presc = {{7{s.cal[9]}}, s.cal};
		end
		if (rif.wr_en)
		begin
			n.key1 = 1'b0;
			n.armed = 1'b0;
			case (wa)
				OFS_UNLOCK:
				begin
					n.key1 = w == KEY_A;
					n.armed = s.key1 && w == KEY_B;
				end
				OFS_CONTROL:
				begin
					n.cal = w[CAL_LSB +: 10];
					n.sidl = w[SIDL_BIT];
					n.sel = w[SEL_BIT];
					n.oe = w[OE_BIT];
					n.vwe = w[VWE_BIT] && (s.vwe || s.armed);
					if (s.vwe)
						n.on = w[ON_BIT];
				end
				OFS_ALARM:
				begin
					n.aen = w[AEN_BIT];
					n.wrap = w[WRAP_BIT];
					n.alarm_interval_select = w[ALARM_INTERVAL_SELECT_LSB +: 4];
					n.rpt = w[RPT_LSB +: 8];
					if (!s.aen)
						n.pulse = w[PIV_BIT];
				end
				OFS_TIME:
				begin
					if (s.vwe)
					begin
						n.tv = w & TIME_MASK;
						if (rif.wr_strb[1])
						begin
							n.half = 1'b0;
							n.presc = 17'h0_0000;
						end
					end
				end
				default:
				begin
				end
			endcase
		end
		// Hardware event is applied last so it is never lost to a write
		if (evt)
		begin
			n.evt = 1'b1;
			n.pulse = ~n.pulse;
			if (s.rpt != 8'h00)
				n.rpt = s.rpt - 8'h01;
			else if (s.wrap)
				n.rpt = 8'hFF;
			else
				n.aen = 1'b0;
		end
		// pin driven only with output enable
		n.pin = n.oe && (n.sel ? n.half : n.pulse);
		n.pin_oe = n.oe;
	end

	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			s <= '0;
		else
			s <= n;
	end

	assign rtc_pin_out = s.pin;
	assign rtc_pin_oe_out = s.pin_oe;
	assign day_rollover_out = s.day;
	assign alarm_event_out = s.evt;
endmodule

// ==== test/rtc_core_chk.sv ====
// Port checker for rtc_core: bus answers, readback zeros, pin, events.
// Assumes one clock and the asynchronous active-high reset of the core.
`timescale 1ns/1ps
module rtc_core_chk
	import rtc_pkg::*;
(
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	input  wire logic [1:0]  axi_bresp_out,
	input  wire logic        axi_bvalid_out,
	input  wire logic        axi_bready_in,
	input  wire logic [7:0]  axi_araddr_in,
	input  wire logic        axi_arvalid_in,
	input  wire logic        axi_arready_out,
	input  wire logic [31:0] axi_rdata_out,
	input  wire logic [1:0]  axi_rresp_out,
	input  wire logic        axi_rvalid_out,
	input  wire logic        axi_rready_in,
	input  wire logic        rtc_pin_out,
	input  wire logic        rtc_pin_oe_out,
	input  wire logic        alarm_event_out
);
	logic [5:0] read_word;
	logic       is_alarm;
	logic       is_time;
	logic       is_hole;

	// The read address is gone after AR; keep it for the R beat
	always_ff @(posedge sys_clk_in or posedge rst_in)
		if (rst_in)
			read_word <= 6'h00;
		else if (axi_arvalid_in && axi_arready_out)
			read_word <= axi_araddr_in[7:2];

	assign is_alarm = read_word == OFS_ALARM[7:2];
	assign is_time = read_word == OFS_TIME[7:2];
	assign is_hole = !(is_alarm || is_time || read_word == OFS_CONTROL[7:2]
		|| read_word == OFS_UNLOCK[7:2]);

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);

	a_pin_quiet: assert property (!rtc_pin_oe_out |-> !rtc_pin_out)
		else $error("pin active while output disabled");
	a_alarm_upper_zero: assert property
		(axi_rvalid_out && is_alarm |-> axi_rdata_out[31:16] == 16'h0000)
		else $error("alarm control upper half not zero");
	a_time_unused_zero: assert property
		(axi_rvalid_out && is_time |-> (axi_rdata_out & ~TIME_MASK) == 0)
		else $error("time unused bits not zero");
	a_hole_error: assert property (axi_rvalid_out && is_hole
		|-> axi_rresp_out == RESP_SLVERR && axi_rdata_out == 32'h0000_0000)
		else $error("unmapped read not refused");
	a_mapped_okay: assert property
		(axi_rvalid_out && !is_hole |-> axi_rresp_out == RESP_OKAY)
		else $error("mapped read refused");
	a_read_answer: assert property
		(axi_arvalid_in && axi_arready_out |=> ##1 axi_rvalid_out)
		else $error("read answer late");
	a_read_hold: assert property (axi_rvalid_out && !axi_rready_in
		|=> axi_rvalid_out && $stable(axi_rdata_out))
		else $error("read data dropped before taken");
	a_bresp_hold: assert property (axi_bvalid_out && !axi_bready_in
		|=> axi_bvalid_out && $stable(axi_bresp_out))
		else $error("write response dropped before taken");
	a_event_spacing: assert property
		(alarm_event_out |=> !alarm_event_out [*8])
		else $error("alarm events too close");
endmodule

bind rtc_core rtc_core_chk chk (
	.sys_clk_in(sys_clk_in),
	.rst_in(rst_in),
	.axi_bresp_out(axi_bresp_out),
	.axi_bvalid_out(axi_bvalid_out),
	.axi_bready_in(axi_bready_in),
	.axi_araddr_in(axi_araddr_in),
	.axi_arvalid_in(axi_arvalid_in),
	.axi_arready_out(axi_arready_out),
	.axi_rdata_out(axi_rdata_out),
	.axi_rresp_out(axi_rresp_out),
	.axi_rvalid_out(axi_rvalid_out),
	.axi_rready_in(axi_rready_in),
	.rtc_pin_out(rtc_pin_out),
	.rtc_pin_oe_out(rtc_pin_oe_out),
	.alarm_event_out(alarm_event_out)
);

// ==== test/tb_top.sv ====
// Self-checking bench for rtc_core, driven over its AXI4-Lite port.
// Assumes shortened prescaler: 2 clocks a tick, 64 ticks a half second.
`timescale 1ns/1ps
module tb_top;
	import rtc_pkg::*;
	typedef struct {
		string       nm;
		logic [31:0] m;
		logic [31:0] e;
	} note_t;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	logic        clk, rst, awv, wv, arv, pin, oe, day, evt;
	logic        aw_rdy, w_rdy, b_vld, ar_rdy, r_vld;
	logic [1:0]  bresp, rresp;
	logic [7:0]  awa, ara;
	logic [31:0] wd, dv, at, ad, rdata, tv;
	logic [3:0]  codes [3] = '{4'h0, 4'h1, 4'hA};
	int          cnts [3] = '{2, 1, 0};
	note_t       q [$];
	note_t       nt;
	int          fails = 0, n_tests = 0, cyc = 0, nev = 0, nday = 0;
	int          e0, r0, t0, seed, d0;

	rtc_core #(.RTC_DIV_CYCLES(2), .HALF_SEC_TICKS(64)) uut (
		.sys_clk_in(clk), .rst_in(rst),
		.axi_awaddr_in(awa), .axi_awvalid_in(awv),
		.axi_awready_out(aw_rdy), .axi_wdata_in(wd),
		.axi_wstrb_in(4'hF), .axi_wvalid_in(wv), .axi_wready_out(w_rdy),
		.axi_bresp_out(bresp), .axi_bvalid_out(b_vld),
		.axi_bready_in(1'b1), .axi_araddr_in(ara), .axi_arvalid_in(arv),
		.axi_arready_out(ar_rdy), .axi_rdata_out(rdata),
		.axi_rresp_out(rresp), .axi_rvalid_out(r_vld),
		.axi_rready_in(1'b1), .date_value_in(dv), .alarm_time_in(at),
		.alarm_date_in(ad), .rtc_pin_out(pin), .rtc_pin_oe_out(oe),
		.day_rollover_out(day), .alarm_event_out(evt)
	);

	always #2 clk = ~clk;

	task automatic complete_run();
		// A note still queued means an answer never came
		if (q.size() != 0)
			fails++;
		$display("checks %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Free-running cycle count, event count and hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (evt)
			nev <= nev + 1;
		if (day)
			nday <= nday + 1;
		if (cyc == 6000)
		begin
			fails++;
			complete_run();
		end
	end

	// Oldest note is matched against each taken answer
	always @(posedge clk)
		if (r_vld || b_vld)
		begin
			nt = q.pop_front();
			chk(nt.nm, nt.e, (r_vld ? rdata : {30'h0, bresp}) & nt.m);
		end

	// next request waits a cycle after each commit
	task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
		q.push_back('{"bresp", 32'h3, {30'h0, r}});
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awv && aw_rdy)
				awv <= 1'b0;
			if (wv && w_rdy)
				wv <= 1'b0;
		end
		while (!b_vld);
	endtask

	// quick reads: the read is finished within a few clocks
	task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] e,
		string nm);
		q.push_back('{nm, m, e});
		ara <= a;
		arv <= 1'b1;
		do
			@(posedge clk);
		while (!ar_rdy);
		arv <= 1'b0;
		do
			@(posedge clk);
		while (!r_vld);
	endtask

	task automatic at_cyc(int t);
		while (cyc < t)
			@(posedge clk);
	endtask

	// sync window: restarting the seconds keeps alarm writes safe
	task automatic realign();
		wr(OFS_TIME, 32'h1234_5600, RESP_OKAY);
		r0 = cyc;
	endtask

	// Valid BCD time, seconds units below 9 so a tick never carries
	function automatic logic [31:0] bcd_time();
		logic [31:0] r;
		r = $random(seed);
		return {3'h0, r[0], 4'(r[7:4] % 10), 1'b0, 3'(r[10:8] % 6),
			4'(r[15:12] % 10), 1'b0, 3'(r[18:16] % 6),
			4'(r[23:20] % 9), r[31:24]};
	endfunction

	initial
	begin
		clk = 0;
		rst = 1;
		awv = 0;
		wv = 0;
		arv = 0;
		awa = 0;
		ara = 0;
		wd = 0;
		seed = 53590;
		dv = $random(seed);
		at = $random(seed);
		ad = $random(seed);
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 4; i++)
			rd(8'(i * 16), ALL, 32'h0, "reset");
		wr(OFS_CONTROL, 32'h0000_8009, RESP_OKAY);
		rd(OFS_CONTROL, 32'h0000_80C9, 32'h1, "ctl"); // locked
		tv = bcd_time();
		wr(OFS_TIME, tv, RESP_OKAY);
		rd(OFS_TIME, ALL, 32'h0, "time"); // locked
		wr(8'h40, tv, RESP_SLVERR);
		rd(8'h44, ALL, 32'h0, "hole");
		wr(OFS_UNLOCK, KEY_A, RESP_OKAY);
		wr(OFS_UNLOCK, KEY_B, RESP_OKAY);
		wr(OFS_CONTROL, 32'h0000_0008, RESP_OKAY);
		wr(OFS_CONTROL, 32'h03FF_8089, RESP_OKAY);
		rd(OFS_CONTROL, 32'hFFFF_FFF9, 32'h03FF_80C9, "ctl");
		tv = bcd_time();
		wr(OFS_TIME, tv, RESP_OKAY);
		t0 = cyc;
		rd(OFS_TIME, ALL, tv & TIME_MASK, "time"); // digits
		rd(OFS_CONTROL, 32'h6, 32'h0, "half"); // cleared
		at_cyc(t0 + 100);
		rd(OFS_ALARM, 32'h1000, 32'h1000, "sync"); // near edge
		at_cyc(t0 + 160);
		rd(OFS_CONTROL, 32'h6, 32'h2, "half"); // late half
		chk("pin", 32'h1, {31'h0, pin}); // seconds clock
		at_cyc(t0 + 235);
		rd(OFS_CONTROL, 32'h6, 32'h6, "ripple"); // ripple
		at_cyc(t0 + 290);
		rd(OFS_TIME, ALL, (tv & TIME_MASK) + 32'h100, "time");
		chk("pin", 32'h0, {31'h0, pin}); // first half
		wr(OFS_CONTROL, 32'h03FF_8009, RESP_OKAY);
		realign();
		wr(OFS_ALARM, 32'h0000_2000, RESP_OKAY);
		rd(OFS_ALARM, 32'h2000, 32'h2000, "piv"); // writable
		chk("pin", 32'h1, {31'h0, pin}); // pulse start
		e0 = nev;
		wr(OFS_ALARM, 32'h0000_A002, RESP_OKAY);
		at_cyc(r0 + 150);
		rd(OFS_ALARM, 32'hA0FF, 32'h8001, "alarm"); // toggle
		wr(OFS_ALARM, 32'h0000_A001, RESP_OKAY);
		rd(OFS_ALARM, 32'hA0FF, 32'h8001, "alarm"); // read only
		at_cyc(r0 + 600);
		chk("events", 32'h3, 32'(nev - e0)); // N plus one
		rd(OFS_ALARM, 32'h80FF, 32'h0, "alarm"); // self clear
		chk("pin", 32'h0, {31'h0, pin}); // odd toggles
		realign();
		wr(OFS_ALARM, 32'h0000_C000, RESP_OKAY);
		at_cyc(r0 + 150);
		rd(OFS_ALARM, 32'hC0FF, 32'hC0FF, "wrap"); // wrap
		wr(OFS_ALARM, 32'h0, RESP_OKAY);
		e0 = nev;
		at_cyc(r0 + 450);
		chk("events", 32'h0, 32'(nev - e0)); // disabled
		for (int i = 0; i < 3; i++)
		begin
			realign();
			e0 = nev;
			wr(OFS_ALARM, {16'h0, 4'hC, codes[i], 8'h0}, RESP_OKAY);
			at_cyc(r0 + 300);
			chk("events", 32'(cnts[i]), 32'(nev - e0)); // period
			wr(OFS_ALARM, 32'h0, RESP_OKAY);
		end
		// Midnight rollover on February 29, common year then leap year
		for (int y = 0; y < 2; y++)
		begin
			dv <= y ? 32'h2402_2900 : 32'h2302_2900;
			at <= 32'h0000_0000;
			ad <= 32'h0002_2900;
			e0 = nev;
			d0 = nday;
			wr(OFS_TIME, 32'h2359_5900, RESP_OKAY);
			r0 = cyc;
			wr(OFS_ALARM, 32'h0000_8900, RESP_OKAY);
			at_cyc(r0 + 300);
			chk("days", 32'h1, 32'(nday - d0)); // hours wrap
			chk("events", 32'(y), 32'(nev - e0)); // leap only
			rd(OFS_TIME, ALL, 32'h0, "midnight"); // midnight
		end
		wr(OFS_CONTROL, 32'h03FF_8081, RESP_OKAY);
		wr(OFS_CONTROL, 32'h0000_0080, RESP_OKAY);
		rd(OFS_CONTROL, 32'h80C9, 32'h80C0, "ctl"); // on kept
		chk("pin", 32'h0, {30'h0, oe, pin}); // pin off
		wr(OFS_TIME, 32'h1234_5600, RESP_OKAY);
		rd(OFS_TIME, 32'hFFFF_0000, 32'h0, "time"); // locked
		// Let the watcher take the last answer first
		@(posedge clk);
		complete_run();
	end
endmodule
